// ---- core/maint_pkg.sv ----
// constants, register map and types for the maintenance command interpreter
package maint_pkg;
  // register byte offsets on the register port
  localparam logic [3:0] OFF_CTRL = 4'h0;
  localparam logic [3:0] OFF_CMD  = 4'h2;
  localparam logic [3:0] OFF_OP1  = 4'h4;
  localparam logic [3:0] OFF_OP2  = 4'h6;
  localparam logic [3:0] OFF_EXT  = 4'h8;

  // lower control byte fields
  localparam int CTL_EN_A     = 0;
  localparam int CTL_SEL_B    = 1;
  localparam int CTL_SEL_A    = 2;
  localparam int CTL_EN_B     = 4;
  // upper control byte fields (bit index within the 16-bit word)
  localparam int CTL_MAINTENANCE_REQUEST_BIT  = 8;
  localparam int CTL_MASTER_CLEAR_BIT  = 14;

  // command/status byte fields
  localparam int CMD_FN_LSB   = 0;
  localparam int CMD_FLAG_B   = 4;
  localparam int CMD_FLAG_A   = 5;
  localparam int CMD_RDY      = 7;

  // function codes
  localparam logic [3:0] FN_RSVD   = 4'h0;
  localparam logic [3:0] FN_RD     = 4'h1;
  localparam logic [3:0] FN_WR     = 4'h2;
  localparam logic [3:0] FN_BLKOUT = 4'h3;
  localparam logic [3:0] FN_BLKIN  = 4'h4;
  localparam logic [3:0] FN_PC     = 4'h5;
  localparam logic [3:0] FN_LOOP   = 4'h6;
  localparam logic [3:0] FN_IRQ    = 4'h7;

  // reset values
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [7:0]  RST_BYTE = 8'h00;

  // self-test threshold and block geometry
  localparam logic [3:0] SELFTEST_MIN = 4'hC;
  localparam logic [7:0] BLK_LAST     = 8'hFF;
  localparam int         HOST_AW      = 22;
  localparam int         EXT_BITS     = 6;

  // null clock timing
  localparam int CLK_HZ        = 125_000_000;
  localparam int NULL_KBPS     = 56;
  localparam int NULL_HALF_CYC = CLK_HZ / (2 * NULL_KBPS * 1000);

  typedef enum logic [3:0] {
    S_IDLE, S_RD, S_RD_CAP, S_WR, S_BO_RD, S_BO_LAT, S_BO_DMA, S_BI_DMA, S_BI_WR, S_DONE
  } state_t;
endpackage : maint_pkg

// ---- core/maint_mem_if.sv ----
// byte-wide port between the interpreter and its internal memory
`timescale 1ns/1ps
interface maint_mem_if #(parameter int AW = 16);
  logic [AW-1:0] addr;
  logic [7:0]    wdata;
  logic          we;
  logic [7:0]    rdata;

  modport ctrl (output addr, output wdata, output we, input rdata);
  modport mem  (input addr, input wdata, input we, output rdata);
endinterface : maint_mem_if

// ---- core/maint_mem.sv ----
// internal controller memory, one byte per address, one-cycle read
`timescale 1ns/1ps
module maint_mem #(
  parameter int AW = 16
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // memory port
  maint_mem_if.mem  port
);
  logic [7:0] store [0:(1<<AW)-1];

  // array has no reset: contents are whatever software last wrote
  always_ff @(posedge clk_i) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  // registered read so the interpreter sees data one cycle after address
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port.rdata <= 8'h00;
    end else begin
      port.rdata <= store[port.addr];
    end
  end
endmodule : maint_mem

// ---- core/maint_loop_cmd.sv ----
// maintenance-mode command interpreter with internal memory and block DMA
`timescale 1ns/1ps
module maint_loop_cmd
  import maint_pkg::*;
#(
  parameter int AW        = 16,
  parameter int NULL_HALF = maint_pkg::NULL_HALF_CYC
) (
  // clock and reset
  input  wire logic                          clk_i,
  input  wire logic                          rst_n_i,
  // register port
  input  wire logic [3:0]                    reg_addr_i,
  input  wire logic [1:0]                    reg_be_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  input  wire logic [15:0]                   reg_wdata_i,
  output logic [15:0]                        reg_rdata_o,
  // self-test progress and addressing strap
  input  wire logic [3:0]                    selftest_count_i,
  input  wire logic                          addr22_mode_i,
  // internal processor side
  input  wire logic                          cpu_irq_a_i,
  input  wire logic                          cpu_irq_b_i,
  output logic                               pc_load_o,
  output logic [15:0]                        pc_value_o,
  output logic                               irq_disable_clr_o,
  output logic                               irq_sel_a_o,
  output logic                               irq_sel_b_o,
  // host interrupts
  output logic                               host_irq_a_o,
  output logic                               host_irq_b_o,
  // host memory DMA
  output logic                               dma_req_o,
  output logic                               dma_write_o,
  output logic [maint_pkg::HOST_AW-1:0]      dma_addr_o,
  output logic [7:0]                         dma_wdata_o,
  input  wire logic                          dma_ack_i,
  input  wire logic [7:0]                    dma_rdata_i,
  // mode and diagnostics
  output logic                               maint_mode_o,
  output logic                               loopback_o,
  output logic                               null_clk_o
);
  import maint_pkg::*;

  logic [7:0]  ctl_lo_ff;
  logic [3:0]  fn_ff;
  logic        flag_a_ff, flag_b_ff, rdy_ff;
  logic [15:0] op1_ff, op2_ff;
  logic        maint_ff, pend_ff;
  logic        m22_s1_ff, m22_ff;
  state_t      state_ff, nxt_state;
  logic [7:0]  cnt_ff;
  logic [7:0]  in_byte_ff, ext_ff; // extension high byte is never stored
  logic        dma_req_ff, dma_wr_ff;
  logic [7:0]  dma_data_ff;
  logic        loop_ff, null_clk_ff;
  logic [15:0] null_cnt_ff;
  logic        pc_load_ff, idc_ff, irq_a_ff, irq_b_ff;
  logic [15:0] rdata_ff;

  logic wr_ctrl, wr_cmd, wr_op1, wr_op2, wr_ext;
  logic clr_w, enter_w, cmd_go, fsm_done, fn_irq_w, fn_loop_w, fn_pc_w, cap_rd;
  logic [HOST_AW-1:0] host_base;
  maint_mem_if #(.AW(AW)) mem_bus ();

  maint_mem #(.AW(AW)) u_mem (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .port    (mem_bus.mem)
  );

  // register write decode
  assign wr_ctrl = reg_wr_i && (reg_addr_i == OFF_CTRL);
  assign wr_cmd  = reg_wr_i && (reg_addr_i == OFF_CMD);
  assign wr_op1  = reg_wr_i && (reg_addr_i == OFF_OP1);
  assign wr_op2  = reg_wr_i && (reg_addr_i == OFF_OP2);
  assign wr_ext  = reg_wr_i && (reg_addr_i == OFF_EXT);

  // master clear from the upper control byte; request must ride with it
  assign clr_w   = wr_ctrl && reg_be_i[1] && reg_wdata_i[CTL_MASTER_CLEAR_BIT];
  assign enter_w = pend_ff && (selftest_count_i >= SELFTEST_MIN);

  // a new function is accepted only while ready; others are dropped
  assign cmd_go  = maint_ff && rdy_ff && wr_cmd && reg_be_i[0] && !clr_w;

  // strap is a pin, so two flops before use
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      m22_s1_ff <= 1'b0;
      m22_ff    <= 1'b0;
    end else begin
      m22_s1_ff <= addr22_mode_i;
      m22_ff    <= m22_s1_ff;
    end
  end

  // maintenance entry and exit
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      maint_ff <= 1'b0;
      pend_ff  <= 1'b0;
    end else if (clr_w) begin
      maint_ff <= 1'b0;
      pend_ff  <= reg_wdata_i[CTL_MAINTENANCE_REQUEST_BIT];
    end else if (enter_w) begin
      maint_ff <= 1'b1;
      pend_ff  <= 1'b0;
    end
  end

  // lower control byte: enables and interrupt selects
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ctl_lo_ff <= RST_BYTE;
    end else if (wr_ctrl && reg_be_i[0]) begin
      ctl_lo_ff <= reg_wdata_i[7:0];
    end
  end

  // operand registers; a function-1 result overrides a host write
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op1_ff <= RST_WORD;
      op2_ff <= RST_WORD;
      ext_ff <= RST_BYTE;
    end else begin
      if (wr_op1 && reg_be_i[0]) op1_ff[7:0]  <= reg_wdata_i[7:0];
      if (wr_op1 && reg_be_i[1]) op1_ff[15:8] <= reg_wdata_i[15:8];
      if (cap_rd) begin
        op2_ff <= {8'h00, mem_bus.rdata};
      end else begin
        if (wr_op2 && reg_be_i[0]) op2_ff[7:0]  <= reg_wdata_i[7:0];
        if (wr_op2 && reg_be_i[1]) op2_ff[15:8] <= reg_wdata_i[15:8];
      end
      if (wr_ext && reg_be_i[0]) ext_ff <= reg_wdata_i[7:0];
    end
  end

  // command/status byte: code, sticky flags, ready
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fn_ff     <= FN_RSVD;
      flag_a_ff <= 1'b0;
      flag_b_ff <= 1'b0;
      rdy_ff    <= 1'b0;
    end else begin
      if (cmd_go) fn_ff <= reg_wdata_i[CMD_FN_LSB +: 4];
      // write one clears; a same-cycle set wins
      if ((cpu_irq_a_i && maint_ff) || fn_irq_w) begin
        flag_a_ff <= 1'b1;
      end else if (wr_cmd && reg_be_i[0] && reg_wdata_i[CMD_FLAG_A]) begin
        flag_a_ff <= 1'b0;
      end
      if ((cpu_irq_b_i && maint_ff) || fn_irq_w) begin
        flag_b_ff <= 1'b1;
      end else if (wr_cmd && reg_be_i[0] && reg_wdata_i[CMD_FLAG_B]) begin
        flag_b_ff <= 1'b0;
      end
      if (clr_w) begin
        rdy_ff <= 1'b0;
      end else if (enter_w || fsm_done) begin
        rdy_ff <= 1'b1;
      end else if (cmd_go) begin
        rdy_ff <= 1'b0;
      end
    end
  end

  // function dispatch and block sequencing
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      S_IDLE: begin
        if (cmd_go) begin
          case (reg_wdata_i[CMD_FN_LSB +: 4])
            FN_RD:     nxt_state = S_RD;
            FN_WR:     nxt_state = S_WR;
            FN_BLKOUT: nxt_state = S_BO_RD;
            FN_BLKIN:  nxt_state = S_BI_DMA;
            default:   nxt_state = S_DONE;
          endcase
        end
      end
      S_RD:     nxt_state = S_RD_CAP;
      S_RD_CAP: nxt_state = S_DONE;
      S_WR:     nxt_state = S_DONE;
      S_BO_RD:  nxt_state = S_BO_LAT;
      S_BO_LAT: nxt_state = S_BO_DMA;
      S_BO_DMA: begin
        if (dma_ack_i) nxt_state = (cnt_ff == BLK_LAST) ? S_DONE : S_BO_RD;
      end
      S_BI_DMA: begin
        if (dma_ack_i && dma_req_ff) nxt_state = S_BI_WR;
      end
      S_BI_WR:  nxt_state = (cnt_ff == BLK_LAST) ? S_DONE : S_BI_DMA;
      S_DONE:   nxt_state = S_IDLE;
      default:  nxt_state = S_IDLE;
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_ff <= S_IDLE;
    end else if (clr_w) begin
      state_ff <= S_IDLE; // master clear aborts any function
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign fsm_done  = (state_ff == S_DONE);
  assign cap_rd    = (state_ff == S_RD_CAP);
  assign fn_irq_w  = cmd_go && (reg_wdata_i[CMD_FN_LSB +: 4] == FN_IRQ);
  assign fn_loop_w = cmd_go && (reg_wdata_i[CMD_FN_LSB +: 4] == FN_LOOP);
  assign fn_pc_w   = cmd_go && (reg_wdata_i[CMD_FN_LSB +: 4] == FN_PC);

  // internal memory port; block address drops the low byte of the pointer
  always_comb begin
    mem_bus.we    = 1'b0;
    mem_bus.wdata = op2_ff[7:0];
    mem_bus.addr  = op1_ff[AW-1:0];
    case (state_ff)
      S_WR: begin
        mem_bus.we = 1'b1;
      end
      S_BO_RD, S_BO_LAT, S_BO_DMA: begin
        mem_bus.addr = {op1_ff[AW-1:8], cnt_ff};
      end
      S_BI_WR: begin
        mem_bus.we    = 1'b1;
        mem_bus.wdata = in_byte_ff;
        mem_bus.addr  = {op1_ff[AW-1:8], cnt_ff};
      end
      default: begin
        mem_bus.we = 1'b0;
      end
    endcase
  end

  // host address: extension byte only counts in 22-bit addressing
  assign host_base = m22_ff ? {ext_ff[EXT_BITS-1:0], op2_ff} : {{EXT_BITS{1'b0}}, op2_ff};

  // byte counter through the 256-byte block
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_ff <= 8'h00;
    end else if (state_ff == S_IDLE) begin
      cnt_ff <= 8'h00;
    end else if ((state_ff == S_BO_DMA && dma_ack_i) || state_ff == S_BI_WR) begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // DMA request held until acknowledged or master clear; data and address stay stable meanwhile
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      dma_req_ff  <= 1'b0;
      dma_wr_ff   <= 1'b0;
      dma_data_ff <= 8'h00;
      in_byte_ff  <= 8'h00;
      dma_addr_o  <= '0;
    end else if (clr_w) begin
      dma_req_ff <= 1'b0;
    end else begin
      if (state_ff == S_BO_LAT) begin
        dma_data_ff <= mem_bus.rdata;
        dma_wr_ff   <= 1'b1;
        dma_req_ff  <= 1'b1;
        dma_addr_o  <= host_base + {{(HOST_AW-8){1'b0}}, cnt_ff};
      end else if (state_ff == S_BI_DMA && !dma_req_ff) begin
        dma_wr_ff  <= 1'b0;
        dma_req_ff <= 1'b1;
        dma_addr_o <= host_base + {{(HOST_AW-8){1'b0}}, cnt_ff};
      end else if (dma_req_ff && dma_ack_i) begin
        dma_req_ff <= 1'b0;
        if (!dma_wr_ff) in_byte_ff <= dma_rdata_i;
      end
    end
  end

  // program counter load and interrupt-disable clear are one-cycle pulses
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pc_load_ff <= 1'b0;
      pc_value_o <= RST_WORD;
      idc_ff     <= 1'b0;
    end else begin
      pc_load_ff <= fn_pc_w;
      if (fn_pc_w) pc_value_o <= op1_ff;
      idc_ff     <= fn_irq_w;
    end
  end

  // loopback stays on until maintenance is left
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      loop_ff <= 1'b0;
    end else if (clr_w || !maint_ff) begin
      loop_ff <= 1'b0;
    end else if (fn_loop_w) begin
      loop_ff <= 1'b1;
    end
  end

  // null clock divider; restarts on enable so the first bit is full length
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      null_cnt_ff <= 16'h0000;
      null_clk_ff <= 1'b0;
    end else if (!loop_ff) begin
      null_cnt_ff <= 16'h0000;
      null_clk_ff <= 1'b0;
    end else if (null_cnt_ff == 16'(NULL_HALF - 1)) begin
      null_cnt_ff <= 16'h0000;
      null_clk_ff <= ~null_clk_ff;
    end else begin
      null_cnt_ff <= null_cnt_ff + 16'h0001;
    end
  end

  // host interrupts registered so they are glitch free
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      irq_a_ff <= 1'b0;
      irq_b_ff <= 1'b0;
    end else begin
      irq_a_ff <= maint_ff && flag_a_ff && ctl_lo_ff[CTL_EN_A];
      irq_b_ff <= maint_ff && flag_b_ff && ctl_lo_ff[CTL_EN_B];
    end
  end

  // register read data, one cycle after the read strobe; unmapped reads zero
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_ff <= RST_WORD;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        OFF_CTRL: rdata_ff <= {7'h00, maint_ff | pend_ff, ctl_lo_ff};
        OFF_CMD:  rdata_ff <= {8'h00, rdy_ff, 1'b0, flag_a_ff, flag_b_ff, fn_ff};
        OFF_OP1:  rdata_ff <= op1_ff;
        OFF_OP2:  rdata_ff <= op2_ff;
        OFF_EXT:  rdata_ff <= {8'h00, ext_ff};
        default:  rdata_ff <= RST_WORD;
      endcase
    end
  end

  // output drive
  assign reg_rdata_o       = rdata_ff;
  assign dma_req_o         = dma_req_ff;
  assign dma_write_o       = dma_wr_ff;
  assign dma_wdata_o       = dma_data_ff;
  assign pc_load_o         = pc_load_ff;
  assign irq_disable_clr_o = idc_ff;
  assign irq_sel_a_o       = ctl_lo_ff[CTL_SEL_A];
  assign irq_sel_b_o       = ctl_lo_ff[CTL_SEL_B];
  assign host_irq_a_o      = irq_a_ff;
  assign host_irq_b_o      = irq_b_ff;
  assign maint_mode_o      = maint_ff;
  assign loopback_o        = loop_ff;
  assign null_clk_o        = null_clk_ff;
endmodule : maint_loop_cmd

// ---- tb/maint_loop_cmd_sva.sv ----
// assertion checker for the maintenance command interpreter ports
`timescale 1ns/1ps
module maint_loop_cmd_sva
  import maint_pkg::*;
#(
  parameter int NULL_HALF = 4
) (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // register port
  input wire logic [3:0]  reg_addr_i,
  input wire logic [1:0]  reg_be_i,
  input wire logic        reg_wr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic [3:0]  selftest_count_i,
  // processor and host side
  input wire logic        pc_load_o,
  input wire logic [15:0] pc_value_o,
  input wire logic        irq_disable_clr_o,
  input wire logic        host_irq_a_o,
  input wire logic        host_irq_b_o,
  // dma and mode
  input wire logic        dma_req_o,
  input wire logic        dma_write_o,
  input wire logic [21:0] dma_addr_o,
  input wire logic [7:0]  dma_wdata_o,
  input wire logic        dma_ack_i,
  input wire logic        maint_mode_o,
  input wire logic        loopback_o,
  input wire logic        null_clk_o
);
  logic        ctl_wr, cmd_wr, mclr_wr;
  logic [15:0] op1_ff, hc_ff;
  logic        en_a_ff, en_b_ff, prev_ff, seen_ff;
  // decoded host writes
  assign ctl_wr  = reg_wr_i && reg_addr_i == OFF_CTRL;
  assign cmd_wr  = reg_wr_i && reg_addr_i == OFF_CMD && reg_be_i[0];
  assign mclr_wr = ctl_wr && reg_be_i[1] && reg_wdata_i[CTL_MASTER_CLEAR_BIT];
  // shadow of operand one and the two host interrupt enables
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      op1_ff  <= RST_WORD;
      en_a_ff <= 1'b0;
      en_b_ff <= 1'b0;
    end else begin
      if (reg_wr_i && reg_addr_i == OFF_OP1 && reg_be_i[0]) op1_ff[7:0] <= reg_wdata_i[7:0];
      if (reg_wr_i && reg_addr_i == OFF_OP1 && reg_be_i[1]) op1_ff[15:8] <= reg_wdata_i[15:8];
      if (ctl_wr && reg_be_i[0]) en_a_ff <= reg_wdata_i[CTL_EN_A];
      if (ctl_wr && reg_be_i[0]) en_b_ff <= reg_wdata_i[CTL_EN_B];
    end
  end
  // half-period counter; first edge after loopback starts has free phase
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prev_ff <= 1'b0;
      seen_ff <= 1'b0;
      hc_ff   <= 16'h0000;
    end else begin
      prev_ff <= null_clk_o;
      hc_ff   <= (null_clk_o != prev_ff) ? 16'h0000 : hc_ff + 16'h0001;
      seen_ff <= loopback_o && (seen_ff || null_clk_o != prev_ff);
    end
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_dma_beat;
    dma_req_o && dma_ack_i;
  endsequence
  sequence s_dma_wait;
    dma_req_o && !dma_ack_i && !mclr_wr;
  endsequence
  a_entry_wait: assert property (!maint_mode_o && selftest_count_i < SELFTEST_MIN |=> !maint_mode_o)
    else $error("maintenance entered before self-tests done");
  a_clear_exits: assert property (mclr_wr && !reg_wdata_i[CTL_MAINTENANCE_REQUEST_BIT] |-> ##2 !maint_mode_o && !loopback_o)
    else $error("master clear did not leave maintenance");
  a_pc_load: assert property (pc_load_o |-> $past(cmd_wr && reg_wdata_i[3:0] == FN_PC) && pc_value_o == op1_ff
    ##1 !pc_load_o)
    else $error("program counter load wrong");
  a_irq_dis_clr: assert property (irq_disable_clr_o |-> $past(cmd_wr && reg_wdata_i[3:0] == FN_IRQ)
    ##1 !irq_disable_clr_o)
    else $error("interrupt disable clear pulse wrong");
  a_dma_release: assert property (s_dma_beat |=> !dma_req_o)
    else $error("dma request held after ack");
  a_dma_hold: assert property (s_dma_wait |=> dma_req_o && $stable(dma_addr_o) && $stable(dma_write_o)
    && (!dma_write_o || $stable(dma_wdata_o)))
    else $error("dma request changed before ack");
  a_irq_a_gate: assert property (host_irq_a_o |-> $past(en_a_ff && maint_mode_o))
    else $error("host interrupt a without enable");
  a_irq_b_gate: assert property (host_irq_b_o |-> $past(en_b_ff && maint_mode_o))
    else $error("host interrupt b without enable");
  a_null_half: assert property (seen_ff && loopback_o |-> ((null_clk_o != prev_ff) ? hc_ff == NULL_HALF - 1
    : hc_ff < NULL_HALF - 1))
    else $error("null clock half period wrong");
endmodule : maint_loop_cmd_sva

// ---- tb/maint_host_mem.sv ----
// host memory model answering the block's dma requests
`timescale 1ns/1ps
module maint_host_mem (
  // clock
  input  wire logic        clk_i,
  // dma request side
  input  wire logic        dma_req_i,
  input  wire logic        dma_write_i,
  input  wire logic [21:0] dma_addr_i,
  input  wire logic [7:0]  dma_wdata_i,
  input  wire logic [1:0]  delay_i,
  output logic             dma_ack_o,
  output logic [7:0]       dma_rdata_o
);
  logic [7:0] mem [int];
  logic [1:0] wait_ff = 2'h0;
  logic [7:0] last_ff = 8'h00;
  // untouched bytes read back as a pattern of their address
  function automatic logic [7:0] pat(input logic [21:0] a);
    return a[7:0] ^ a[15:8] ^ {2'h0, a[21:16]};
  endfunction : pat
  initial dma_ack_o = 1'b0;
  // answer each request after delay_i idle cycles, address as given
  always @(posedge clk_i) begin
    dma_ack_o <= 1'b0;
    if (dma_req_i && !dma_ack_o) begin
      if (wait_ff == delay_i) begin
        wait_ff   <= 2'h0;
        dma_ack_o <= 1'b1;
        if (dma_write_i) mem[dma_addr_i] = dma_wdata_i;
        else last_ff <= mem.exists(dma_addr_i) ? mem[dma_addr_i] : pat(dma_addr_i);
      end else begin
        wait_ff <= wait_ff + 2'h1;
      end
    end
  end
  // data lines carry garbage outside the ack cycle
  assign dma_rdata_o = dma_ack_o ? last_ff : ~last_ff;
endmodule : maint_host_mem

// ---- tb/testbench.sv ----
// self-checking bench for the maintenance command interpreter
`timescale 1ns/1ps
module testbench;
  import maint_pkg::*;
  localparam int NULL_HALF = 4;
  typedef struct packed { logic [15:0] addr; logic [15:0] wdata; logic [15:0] exp; } row_t;
  localparam row_t ROWS [4] = '{'{16'h0000, 16'h00FF, 16'h00FF}, '{16'hFFFF, 16'hC3A5, 16'h00A5},
                                '{16'h0100, 16'h005A, 16'h005A}, '{16'h7F80, 16'h0001, 16'h0001}};
  logic        clk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [3:0]  reg_addr_i = 4'h0;
  logic [1:0]  reg_be_i = 2'h0;
  logic        reg_wr_i = 1'b0;
  logic        reg_rd_i = 1'b0;
  logic [15:0] reg_wdata_i = 16'h0000;
  logic [3:0]  selftest_count_i = 4'hB;
  logic        addr22_mode_i = 1'b1;
  logic        cpu_irq_a_i = 1'b0;
  logic        cpu_irq_b_i = 1'b0;
  logic [1:0]  delay = 2'h0;
  logic [15:0] reg_rdata_o, pc_value_o, pc_seen, rd_data;
  logic        pc_load_o, irq_disable_clr_o, irq_sel_a_o, irq_sel_b_o, host_irq_a_o, host_irq_b_o;
  logic        dma_req_o, dma_write_o, dma_ack_i, maint_mode_o, loopback_o, null_clk_o;
  logic        null_q = 1'b0;
  logic [21:0] dma_addr_o;
  logic [7:0]  dma_wdata_o, dma_rdata_i;
  int          mismatches = 0, comparisons = 0, cycles = 0, pc_cnt = 0, clr_cnt = 0, tog_cnt = 0;
  maint_loop_cmd #(.NULL_HALF(NULL_HALF)) i_maint_loop_cmd (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .selftest_count_i(selftest_count_i),
    .addr22_mode_i(addr22_mode_i), .cpu_irq_a_i(cpu_irq_a_i), .cpu_irq_b_i(cpu_irq_b_i),
    .pc_load_o(pc_load_o), .pc_value_o(pc_value_o), .irq_disable_clr_o(irq_disable_clr_o),
    .irq_sel_a_o(irq_sel_a_o), .irq_sel_b_o(irq_sel_b_o), .host_irq_a_o(host_irq_a_o),
    .host_irq_b_o(host_irq_b_o), .dma_req_o(dma_req_o), .dma_write_o(dma_write_o), .dma_addr_o(dma_addr_o),
    .dma_wdata_o(dma_wdata_o), .dma_ack_i(dma_ack_i), .dma_rdata_i(dma_rdata_i), .maint_mode_o(maint_mode_o),
    .loopback_o(loopback_o), .null_clk_o(null_clk_o));
  maint_host_mem i_maint_host_mem (.clk_i(clk_i), .dma_req_i(dma_req_o), .dma_write_i(dma_write_o),
    .dma_addr_i(dma_addr_o), .dma_wdata_i(dma_wdata_o), .delay_i(delay), .dma_ack_o(dma_ack_i),
    .dma_rdata_o(dma_rdata_i));
  always #4 clk_i = ~clk_i;
  // pulse monitors and hang guard, sampled before the edge updates land
  always @(posedge clk_i) begin
    cycles++;
    null_q <= null_clk_o;
    if (null_clk_o !== null_q) tog_cnt++;
    if (irq_disable_clr_o === 1'b1) clr_cnt++;
    if (pc_load_o === 1'b1) begin
      pc_cnt++;
      pc_seen = pc_value_o;
    end
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("mismatches=%0d comparisons=%0d", mismatches, comparisons);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [21:0] seen, input logic [21:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask : check
  task automatic step(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : step
  // strobe for one edge, then one idle edge so back-to-back calls never re-drive in one step
  task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d);
    reg_addr_i = a;
    reg_be_i = be;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    step(1);
    reg_wr_i = 1'b0;
    step(1);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    step(1);
    reg_rd_i = 1'b0;
    rd_data = reg_rdata_o;
    step(1);
  endtask : rd
  // poll the ready bit with the read strobe held high
  task automatic wait_ready();
    int n;
    n = 0;
    reg_addr_i = OFF_CMD;
    reg_rd_i = 1'b1;
    do begin
      step(1);
      n++;
    end while (reg_rdata_o[CMD_RDY] !== 1'b1 && n < 4000);
    reg_rd_i = 1'b0;
    step(1);
    check(n < 4000, 22'h1);
  endtask : wait_ready
  // functions only after ready, never the reserved code
  task automatic cmd(input logic [3:0] fn);
    wr(OFF_CMD, 2'b01, {12'h000, fn});
    wait_ready();
  endtask : cmd
  initial begin
    step(8);
    check({maint_mode_o, loopback_o, dma_req_o, pc_load_o, host_irq_a_o, host_irq_b_o}, 22'h0);
    rst_n_i = 1'b1;
    step(1);
    foreach (ROWS[i]) begin
      rd(4'(2 * i));
      check(rd_data, RST_WORD);
    end
    rd(OFF_EXT);
    check(rd_data, RST_WORD);
    rd(4'hA);
    check(rd_data, RST_WORD);
    // entry requested while self-tests are still short
    wr(OFF_CTRL, 2'b10, 16'h4100);
    step(10);
    check(maint_mode_o, 22'h0);
    selftest_count_i = SELFTEST_MIN;
    step(3);
    check(maint_mode_o, 22'h1);
    rd(OFF_CMD);
    check(rd_data, 16'h0080);
    // single byte write then read back through operand two
    foreach (ROWS[i]) begin
      wr(OFF_OP1, 2'b11, ROWS[i].addr);
      wr(OFF_OP2, 2'b11, ROWS[i].wdata);
      cmd(FN_WR);
      wr(OFF_OP2, 2'b11, 16'hFFFF);
      cmd(FN_RD);
      rd(OFF_OP1);
      check(rd_data, ROWS[i].addr);
      rd(OFF_OP2);
      check(rd_data, ROWS[i].exp);
    end
    cmd(4'h9);
    // block in across the 16-bit host boundary, extension honoured
    wr(OFF_EXT, 2'b11, 16'hAB15);
    rd(OFF_EXT);
    check(rd_data, 16'h0015);
    wr(OFF_OP1, 2'b11, 16'h1234);
    wr(OFF_OP2, 2'b11, 16'hFF80);
    cmd(FN_BLKIN);
    wr(OFF_OP1, 2'b11, 16'h1200);
    cmd(FN_RD);
    rd(OFF_OP2);
    check(rd_data, {8'h00, i_maint_host_mem.pat(22'h15FF80)});
    // block out with a slow host and the extension ignored
    addr22_mode_i = 1'b0;
    delay = 2'h3;
    wr(OFF_OP1, 2'b11, 16'h12FF);
    wr(OFF_OP2, 2'b11, 16'h4000);
    cmd(FN_BLKOUT);
    for (int n = 0; n < 256; n++)
      check(i_maint_host_mem.mem[22'h004000 + n], i_maint_host_mem.pat(22'h15FF80 + n));
    check(i_maint_host_mem.mem.exists(32'h00154000), 22'h0);
    wr(OFF_OP1, 2'b11, 16'hBEEF);
    cmd(FN_PC);
    check(pc_cnt, 22'h1);
    check(pc_seen, 16'hBEEF);
    // interrupt enables, selects, flag set, clear and mask
    wr(OFF_CTRL, 2'b01, 16'h0017);
    check({irq_sel_a_o, irq_sel_b_o}, 22'h3);
    cmd(FN_IRQ);
    check(clr_cnt, 22'h1);
    check({host_irq_a_o, host_irq_b_o}, 22'h3);
    wr(OFF_CMD, 2'b01, 16'h0036);
    wait_ready();
    check({host_irq_a_o, host_irq_b_o, loopback_o}, 22'h1);
    tog_cnt = 0;
    step(40);
    check(tog_cnt, 22'(40 / NULL_HALF));
    rd(OFF_CMD);
    check(rd_data, 16'h0086);
    wr(OFF_CTRL, 2'b01, 16'h0010);
    cpu_irq_a_i = 1'b1;
    cpu_irq_b_i = 1'b1;
    step(1);
    cpu_irq_a_i = 1'b0;
    cpu_irq_b_i = 1'b0;
    step(3);
    check({host_irq_a_o, host_irq_b_o}, 22'h1);
    rd(OFF_CMD);
    check(rd_data, 16'h00B6);
    // master clear alone leaves maintenance; later functions refused
    wr(OFF_CTRL, 2'b10, 16'h4000);
    step(3);
    check({maint_mode_o, loopback_o, host_irq_b_o}, 22'h0);
    wr(OFF_CMD, 2'b01, 16'h0002);
    step(3);
    rd(OFF_CMD);
    check(rd_data & 16'h008F, 16'h0006);
    stop_test();
  end
endmodule : testbench
bind maint_loop_cmd maint_loop_cmd_sva #(.NULL_HALF(NULL_HALF)) i_maint_loop_cmd_sva (.clk_i(clk_i),
  .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i), .reg_be_i(reg_be_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
  .selftest_count_i(selftest_count_i), .pc_load_o(pc_load_o), .pc_value_o(pc_value_o),
  .irq_disable_clr_o(irq_disable_clr_o), .host_irq_a_o(host_irq_a_o), .host_irq_b_o(host_irq_b_o),
  .dma_req_o(dma_req_o), .dma_write_o(dma_write_o), .dma_addr_o(dma_addr_o), .dma_wdata_o(dma_wdata_o),
  .dma_ack_i(dma_ack_i), .maint_mode_o(maint_mode_o), .loopback_o(loopback_o), .null_clk_o(null_clk_o));
